// ===== rtl/cbs_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module cbs_ctrl #(
  parameter int unsigned NUM_CH = cbs_pkg::NUM_CHANNELS,
  parameter int unsigned TICK_LEN = cbs_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire cbs_pkg::cbs_apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cbs_pkg::cbs_sense_type sense_pins,
  output logic [NUM_CH-1:0] balance_switch,
  output logic gpio3_sink_out,
  output logic gpio3_sink_oe,
  output logic power_action_valid,
  output logic [1:0] power_action
);
  import cbs_pkg::*;

  // the 4-bit selects and the status word only serve sixteen channels
  if (NUM_CH != NUM_CHANNELS || TICK_LEN < 1) begin : g_bad_params
    $error("cbs_ctrl: unsupported parameter values");
  end

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers
  cbs_sense_type sense_meta;
  cbs_sense_type sense;
  // only the second flop feeds logic; the first may go metastable

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sense_meta <= '0;
      sense <= '0;
    end else begin
      sense_meta <= sense_pins;
      sense <= sense_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb decode
  wire apb_setup = apb_req.psel && !apb_req.penable;
  wire apb_access = apb_req.psel && apb_req.penable;
  wire wr_strobe = apb_access && apb_req.pwrite;
  wire [7:0] addr = apb_req.paddr;
  wire [31:0] wdata = apb_req.pwdata;
  wire hit_ctl = addr == REG_CONTROL;
  wire hit_volt = addr == REG_STOP_VOLTS;
  wire hit_mod = addr == REG_MODULE_TIMER;
  wire hit_stat = addr == REG_STATUS;
  wire hit_rem = addr == REG_REMAINING;
  wire hit_chan = addr[7:6] == REG_CHAN_BASE[7:6] && addr[1:0] == 2'h0;
  wire [3:0] chan_idx = addr[5:2];
  wire hit_any = hit_ctl | hit_volt | hit_mod | hit_stat | hit_rem | hit_chan;

  logic fault_en;
  logic therm_en;
  logic [1:0] act_sel;
  logic [3:0] time_sel;
  logic [VOLT_WIDTH-1:0] stop_volts;
  logic [TIMER_WIDTH-1:0] module_setting;
  logic [TIMER_WIDTH-1:0] chan_setting [NUM_CH];

  wire ctl_wr = wr_strobe && hit_ctl;
  wire launch = ctl_wr && wdata[CTL_LAUNCH];
  wire pause_req = ctl_wr && wdata[CTL_PAUSE];
  wire time_go = ctl_wr && wdata[CTL_TIME_GO];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fault_en <= 1'b0;
      therm_en <= 1'b0;
      act_sel <= 2'h0;
      time_sel <= 4'h0;
      stop_volts <= '0;
      module_setting <= '0;
    end else if (wr_strobe) begin
      if (hit_ctl) begin
        fault_en <= wdata[CTL_FAULT_EN];
        therm_en <= wdata[CTL_THERM_EN];
        act_sel <= wdata[CTL_ACT_LO +: 2];
        time_sel <= wdata[CTL_SEL_LO +: 4];
      end
      if (hit_volt) begin
        stop_volts <= wdata[VOLT_WIDTH-1:0];
      end
      if (hit_mod) begin
        module_setting <= wdata[TIMER_WIDTH-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // tick divider
  logic [31:0] tick_count;
  wire tick = tick_count == TICK_LEN - 1;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick_count <= '0;
    end else if (tick) begin
      tick_count <= '0;
    end else begin
      tick_count <= tick_count + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // cell balancing sequencer
  cbs_state_type state;
  cbs_state_type next_state;
  logic [TIMER_WIDTH-1:0] chan_timer [NUM_CH];
  logic [NUM_CH-1:0] chan_active;
  logic [NUM_CH-1:0] chan_by_volts;
  logic cell_balance_complete;
  logic fault_flag;
  logic pause_flag;
  logic thermal_flag;
  logic host_pause;
  logic ever_valid;
  logic [TIMER_WIDTH-1:0] remaining;

  wire any_armed;
  wire [NUM_CH-1:0] armed;
  wire volt_stop_on = stop_volts != '0;
  wire running = state == CBS_RUN;
  wire paused = state == CBS_PAUSE;
  wire die_pause = sense.die_hot;
  wire therm_pause = therm_en && sense.therm_hot;
  wire any_pause = die_pause || therm_pause || host_pause;
  wire fault_hit = fault_en && sense.fault && !paused;
  wire cb_abort = running && fault_hit;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan
      assign armed[g] = chan_setting[g] != '0;
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          chan_setting[g] <= '0;
        end else if (wr_strobe && hit_chan && chan_idx == 4'(g)) begin
          chan_setting[g] <= wdata[TIMER_WIDTH-1:0];
        end
      end
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          chan_timer[g] <= '0;
          chan_active[g] <= 1'b0;
          chan_by_volts[g] <= 1'b0;
        end else if (launch) begin
          chan_timer[g] <= chan_setting[g];
          chan_active[g] <= armed[g];
          chan_by_volts[g] <= 1'b0;
        end else if (cb_abort) begin
          chan_active[g] <= 1'b0;
        end else if (running && chan_active[g]) begin
          if (volt_stop_on && sense.cell_below_stop[g]) begin
            chan_active[g] <= 1'b0;
            chan_by_volts[g] <= 1'b1;
          end else if (chan_timer[g] == '0) begin
            chan_active[g] <= 1'b0;
          end else if (tick) begin
            chan_timer[g] <= chan_timer[g] - 1'b1;
          end
        end
      end
    end
  endgenerate

  assign any_armed = |armed;
  wire all_ended = chan_active == '0;

  always_comb begin
    next_state = state;
    case (state)
      CBS_IDLE: begin
        if (launch && any_armed) begin
          next_state = CBS_RUN;
        end
      end
      CBS_RUN: begin
        // a launch reloads the timers, so it outranks end and abort
        if (launch) begin
          if (!any_armed) begin
            next_state = CBS_IDLE;
          end
        end else if (cb_abort || all_ended) begin
          next_state = CBS_IDLE;
        end else if (any_pause) begin
          next_state = CBS_PAUSE;
        end
      end
      CBS_PAUSE: begin
        if (launch && !any_armed) begin
          next_state = CBS_IDLE;
        end else if (!any_pause) begin
          next_state = CBS_RUN;
        end
      end
      default: next_state = CBS_IDLE;
    endcase
  end

  wire finishing = running && !launch && !cb_abort && all_ended;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= CBS_IDLE;
      cell_balance_complete <= 1'b0;
      fault_flag <= 1'b0;
      pause_flag <= 1'b0;
      thermal_flag <= 1'b0;
      host_pause <= 1'b0;
      ever_valid <= 1'b0;
    end else begin
      state <= next_state;
      if (launch) begin
        cell_balance_complete <= 1'b0;
        fault_flag <= 1'b0;
        thermal_flag <= 1'b0;
        host_pause <= 1'b0;
        ever_valid <= any_armed;
      end else begin
        if (finishing) begin
          cell_balance_complete <= 1'b1;
        end
        if (cb_abort) begin
          fault_flag <= 1'b1;
        end
        if ((running || paused) && (die_pause || therm_pause)) begin
          thermal_flag <= 1'b1;
        end
        if (ctl_wr && (running || paused)) begin
          host_pause <= wdata[CTL_PAUSE];
        end
      end
      pause_flag <= next_state == CBS_PAUSE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // remaining time readout
  // the latch uses the select written with the command, not the old one
  wire [TIMER_WIDTH-1:0] sel_time = chan_timer[wdata[CTL_SEL_LO +: 4]];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      remaining <= REMAIN_INVALID;
    end else if (time_go) begin
      remaining <= ever_valid ? sel_time : REMAIN_INVALID;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // module balancing
  logic module_running_flag;
  logic module_complete_flag;
  logic [TIMER_WIDTH-1:0] mb_count;
  wire mb_volt_hit = sense.aux_running && sense.stack_below_stop;
  wire mb_expired = mb_count >= module_setting;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      module_running_flag <= 1'b0;
      module_complete_flag <= 1'b0;
      mb_count <= '0;
    end else if (launch) begin
      module_running_flag <= module_setting != '0;
      module_complete_flag <= 1'b0;
      mb_count <= '0;
    end else if (module_running_flag) begin
      if (fault_en && sense.fault) begin
        module_running_flag <= 1'b0;
      end else if (mb_expired || mb_volt_hit) begin
        module_running_flag <= 1'b0;
        module_complete_flag <= 1'b1;
      end else if (tick) begin
        mb_count <= mb_count + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  logic mb_enabled_seen;
  logic action_sent;
  wire cb_settled = !ever_valid || cell_balance_complete;
  wire all_complete = cb_settled && (module_complete_flag || !mb_enabled_seen);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      balance_switch <= '0;
      gpio3_sink_out <= 1'b0;
      gpio3_sink_oe <= 1'b0;
      power_action_valid <= 1'b0;
      power_action <= 2'h0;
      mb_enabled_seen <= 1'b0;
      action_sent <= 1'b0;
    end else begin
      balance_switch <= running ? chan_active : '0;
      gpio3_sink_out <= 1'b0;
      gpio3_sink_oe <= module_running_flag;
      power_action_valid <= 1'b0;
      if (launch) begin
        mb_enabled_seen <= module_setting != '0;
        action_sent <= 1'b0;
      end else if (!action_sent && (ever_valid || mb_enabled_seen)
                   && all_complete && !module_running_flag && !fault_flag) begin
        power_action_valid <= 1'b1;
        power_action <= act_sel;
        action_sent <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb read path
  // upper half tells which channels ended on the stop voltage
  wire [31:0] stat_word = {chan_by_volts, 9'h0, module_complete_flag, module_running_flag,
                           thermal_flag, fault_flag, pause_flag, cell_balance_complete,
                           running};
  wire [31:0] ctl_word = {16'h0, time_sel, 2'h0, act_sel, 4'h0,
                          therm_en, fault_en, host_pause, 1'b0};
  wire [31:0] rd_mux =
    hit_ctl ? ctl_word :
    hit_volt ? {24'h0, stop_volts} :
    hit_mod ? {24'h0, module_setting} :
    hit_stat ? stat_word :
    hit_rem ? {24'h0, remaining} :
    hit_chan ? {24'h0, chan_setting[chan_idx]} : 32'h0;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !hit_any;
      prdata <= apb_setup ? rd_mux : 32'h0;
    end
  end
endmodule // cbs_ctrl
`default_nettype wire

// ===== rtl/cbs_pkg.sv
package cbs_pkg;
  localparam int unsigned NUM_CHANNELS = 16;
  localparam int unsigned TIMER_WIDTH = 8;
  localparam int unsigned VOLT_WIDTH = 8;
  localparam int unsigned CLOCK_MHZ = 200;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = TICK_US * CLOCK_MHZ;

  // register byte offsets
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STOP_VOLTS = 8'h04;
  localparam logic [7:0] REG_MODULE_TIMER = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_REMAINING = 8'h10;
  localparam logic [7:0] REG_CHAN_BASE = 8'h40;

  // control register fields
  localparam int unsigned CTL_LAUNCH = 0;
  localparam int unsigned CTL_PAUSE = 1;
  localparam int unsigned CTL_FAULT_EN = 2;
  localparam int unsigned CTL_THERM_EN = 3;
  localparam int unsigned CTL_TIME_GO = 4;
  localparam int unsigned CTL_ACT_LO = 8;
  localparam int unsigned CTL_SEL_LO = 12;

  // status register fields
  localparam int unsigned ST_CB_RUN = 0;
  localparam int unsigned ST_CELL_BALANCE_COMPLETE = 1;
  localparam int unsigned ST_IN_PAUSE = 2;
  localparam int unsigned ST_FAULT = 3;
  localparam int unsigned ST_THERMAL = 4;
  localparam int unsigned ST_MODULE_RUNNING_FLAG = 5;
  localparam int unsigned ST_MODULE_COMPLETE_FLAG = 6;

  localparam logic [7:0] REMAIN_INVALID = 8'hff;
  localparam logic [1:0] ACT_SHUTDOWN = 2'h2;

  typedef enum logic [2:0] {
    CBS_IDLE = 3'b001,
    CBS_RUN = 3'b010,
    CBS_PAUSE = 3'b100
  } cbs_state_type;

  typedef struct packed {
    logic [NUM_CHANNELS-1:0] cell_below_stop;
    logic die_hot;
    logic therm_hot;
    logic fault;
    logic stack_below_stop;
    logic aux_running;
  } cbs_sense_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cbs_apb_req_type;
endpackage

// ===== tb/cbs_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module cbs_ctrl_asserts
  import cbs_pkg::*;
#(
  parameter int unsigned NUM_CH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire cbs_pkg::cbs_apb_req_type apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cbs_pkg::cbs_sense_type sense_pins,
  input wire logic [NUM_CH-1:0] balance_switch,
  input wire logic gpio3_sink_out,
  input wire logic gpio3_sink_oe,
  input wire logic power_action_valid,
  input wire logic [1:0] power_action
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic fault_en, pause_req;
  logic [1:0] act;
  logic [NUM_CH-1:0] nz;
  logic [NUM_CH-1:0] lz [4];
  wire logic wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  wire logic wr_ctl = wr && apb_req.paddr == REG_CONTROL;
  wire logic go = wr_ctl && apb_req.pwdata[CTL_LAUNCH];
  wire logic [7:0] ch_off = apb_req.paddr - REG_CHAN_BASE;
  wire logic wr_ch = wr && apb_req.paddr >= REG_CHAN_BASE && ch_off < 8'h40;
  wire logic [NUM_CH-1:0] armed = lz[0] | lz[1] | lz[2] | lz[3];
  // lz keeps the armed set of the last launches so switch-off lag is allowed
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fault_en <= 1'b0;
      pause_req <= 1'b0;
      act <= 2'h0;
      nz <= '0;
      for (int i = 0; i < 4; i++) lz[i] <= '0;
    end else begin
      if (wr_ctl) fault_en <= apb_req.pwdata[CTL_FAULT_EN];
      if (wr_ctl) pause_req <= apb_req.pwdata[CTL_PAUSE] && !go;
      if (go) act <= apb_req.pwdata[9:8];
      if (wr_ch) nz[ch_off[5:2]] <= |apb_req.pwdata[7:0];
      if (go) lz[0] <= nz;
      for (int i = 1; i < 4; i++) lz[i] <= lz[i-1];
    end
  end
  property p_sw_armed;
    (balance_switch & ~armed) == '0;
  endproperty
  a_sw_armed: assert property (p_sw_armed) else $error("switch on unarmed");
  property p_fault;
    (fault_en && !pause_req && sense_pins.fault && !sense_pins.die_hot
      && !sense_pins.therm_hot) [*4]
      |-> ##[0:3] (balance_switch == '0 && !gpio3_sink_oe);
  endproperty
  a_fault: assert property (p_fault) else $error("fault did not abort");
  property p_die;
    sense_pins.die_hot [*4] |-> ##[0:3] (balance_switch == '0);
  endproperty
  a_die: assert property (p_die) else $error("die heat no pause");
  property p_pause;
    pause_req [*2] |-> ##[0:3] (balance_switch == '0);
  endproperty
  a_pause: assert property (p_pause) else $error("host pause ignored");
  property p_pulse;
    power_action_valid |=> !power_action_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("action not a pulse");
  property p_act;
    power_action_valid |-> power_action == act;
  endproperty
  a_act: assert property (p_act) else $error("wrong power action");
  property p_done;
    power_action_valid |-> ##1 (balance_switch == '0 && !gpio3_sink_oe);
  endproperty
  a_done: assert property (p_done) else $error("done while running");
  property p_sink;
    gpio3_sink_oe |-> gpio3_sink_out == 1'b0;
  endproperty
  a_sink: assert property (p_sink) else $error("sink pin not low");
endmodule // cbs_ctrl_asserts
bind cbs_ctrl cbs_ctrl_asserts #(.NUM_CH(NUM_CH)) i_chk (.clock, .sys_rst,
  .apb_req, .prdata, .pready, .pslverr, .sense_pins, .balance_switch,
  .gpio3_sink_out, .gpio3_sink_oe, .power_action_valid, .power_action);
`default_nettype wire

// ===== tb/cbs_cell_model.sv
`timescale 1ns/100ps
`default_nettype none
module cbs_cell_model
  import cbs_pkg::*;
#(
  parameter int unsigned STACK_N = 40
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire cbs_pkg::cbs_sense_type env,
  input wire logic [NUM_CHANNELS-1:0] balance_switch,
  input wire logic gpio3_sink_oe,
  output var cbs_pkg::cbs_sense_type sense_pins
);
  int drain;
  // stack sags only while some load is drawing current
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) drain <= 0;
    else if (gpio3_sink_oe || |balance_switch) drain <= drain + 1;
    else drain <= 0;
  end
  // stack stop detection as the protector reports it after its restart; per-cell stops pass through from env
  always_comb begin
    sense_pins = env;
    sense_pins.stack_below_stop = drain >= STACK_N;
  end
endmodule // cbs_cell_model
`default_nettype wire

// ===== tb/cell_balance_stop_pause_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cell_balance_stop_pause_ctrl_tb_top;
  import cbs_pkg::*;
  logic clock, sys_rst, pready, pslverr, er, pav, oe, so;
  cbs_apb_req_type rq;
  cbs_sense_type env, sense;
  logic [31:0] prdata, rd, a;
  logic [1:0] pa, act_seen;
  logic [15:0] sw;
  int err_total, checks_done;
  cbs_ctrl #(.TICK_LEN(4)) i_dut (.clock(clock), .sys_rst(sys_rst),
    .apb_req(rq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_pins(sense), .balance_switch(sw), .gpio3_sink_out(so),
    .gpio3_sink_oe(oe), .power_action_valid(pav), .power_action(pa));
  cbs_cell_model i_cells (.clock(clock), .sys_rst(sys_rst), .env(env),
    .balance_switch(sw), .gpio3_sink_oe(oe), .sense_pins(sense));
  always @(posedge clock) if (pav === 1'b1) act_seen <= pa;
  task automatic give_verdict(input bit tmo);
    if (tmo) err_total++;
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n = 0;
    rq <= '{1'b1, 1'b0, w, ad, d};
    @(posedge clock);
    rq.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (n > 50) give_verdict(1);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    rq <= '0;
    @(posedge clock);
  endtask
  task automatic ctl(input logic [31:0] d);
    apb(1'b1, REG_CONTROL, d);
  endtask
  task automatic st;
    apb(1'b0, REG_STATUS, 32'h0);
  endtask
  task automatic rem(input logic [3:0] c, input logic [31:0] base);
    ctl(base | 32'h10 | (32'(c) << 12));
    apb(1'b0, REG_REMAINING, 32'h0);
  endtask
  task automatic wait_st(input int b);
    int n = 0;
    do begin
      st;
      n++;
      if (n > 400) give_verdict(1);
    end while (rd[b] !== 1'b1);
  endtask
  task automatic tm(input logic [15:0] m, input logic [7:0] v);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 8'(REG_CHAN_BASE + 4 * i), m[i] ? 32'(v) : 32'h0);
    end
  endtask
  task automatic s_idle;
    apb(1'b0, REG_REMAINING, 32'h0);
    chk(rd, 32'hff);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    ctl(32'h1);
    cyc(20);
    chk(sw, 0);
    st;
    chk(rd, 0);
    rem(4'h0, 32'h0);
    chk(rd, 32'hff);
  endtask
  task automatic s_timer;
    tm(16'h0021, 8'd3);
    cyc(4);
    chk(sw, 0);
    ctl(32'h201);
    cyc(3);
    chk(sw, 32'h21);
    wait_st(1);
    chk(sw, 0);
    chk(act_seen, 2);
    rem(5, 0);
    chk(rd, 0);
  endtask
  task automatic s_pause;
    tm(16'h0002, 8'd40);
    ctl(32'h5);
    cyc(6);
    chk(sw, 2);
    ctl(32'h6);
    cyc(6);
    chk(sw, 0);
    st;
    chk(rd[2], 1);
    rem(1, 32'h6);
    a = rd;
    env.fault <= 1'b1;
    cyc(30);
    rem(1, 32'h6);
    chk(rd, a);
    st;
    chk(rd[3], 0);
    env.fault <= 1'b0;
    cyc(6);
    ctl(32'h4);
    cyc(6);
    chk(sw, 2);
    wait_st(1);
  endtask
  task automatic s_therm;
    tm(16'h0010, 8'd80);
    ctl(32'h1);
    env.die_hot <= 1'b1;
    cyc(8);
    chk(sw, 0);
    st;
    chk(rd[4], 1);
    env.die_hot <= 1'b0;
    env.therm_hot <= 1'b1;
    cyc(8);
    chk(sw, 32'h10);
    ctl(32'h8);
    cyc(8);
    chk(sw, 0);
    env.therm_hot <= 1'b0;
    cyc(8);
    chk(sw, 32'h10);
    tm(16'h0, 8'd0);
    ctl(32'h1);
    cyc(6);
    chk(sw, 0);
  endtask
  task automatic s_fault;
    tm(16'h0004, 8'd40);
    ctl(32'h5);
    cyc(6);
    env.fault <= 1'b1;
    cyc(8);
    chk(sw, 0);
    st;
    chk(rd[3:1], 3'b100);
    rem(2, 32'h4);
    chk({31'h0, rd != 0}, 1);
    env.fault <= 1'b0;
  endtask
  task automatic s_volt;
    apb(1'b1, REG_STOP_VOLTS, 32'h20);
    env.cell_below_stop <= 16'h0040;
    tm(16'h0048, 8'd80);
    ctl(32'h1);
    cyc(8);
    chk(sw, 32'h8);
    env.cell_below_stop <= 16'hffff;
    wait_st(1);
    st;
    chk(rd[31:16], 32'h48);
    rem(3, 0);
    chk({31'h0, rd != 0}, 1);
    ctl(32'h1);
    wait_st(1);
    env.cell_below_stop <= 16'h0;
    apb(1'b1, REG_STOP_VOLTS, 32'h0);
  endtask
  task automatic s_module;
    apb(1'b1, REG_MODULE_TIMER, 32'd200);
    // a running cell channel shows that the pause reaches cells only
    tm(16'h0001, 8'd80);
    env.aux_running <= 1'b1;
    ctl(32'h1);
    cyc(4);
    chk(oe, 1);
    chk(so, 0);
    st;
    chk(rd[6:5], 1);
    ctl(32'h2);
    cyc(4);
    chk(sw, 0);
    chk(oe, 1);
    wait_st(6);
    chk(oe, 0);
    ctl(32'h1);
    cyc(4);
    chk(oe, 1);
    apb(1'b1, REG_MODULE_TIMER, 32'h0);
    ctl(32'h1);
    cyc(4);
    chk(oe, 0);
    st;
    chk(rd[6], 0);
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    sys_rst = 1'b1;
    rq = '0;
    env = '0;
    act_seen = 2'h0;
    err_total = 0;
    checks_done = 0;
    cyc(10);
    sys_rst <= 1'b0;
    cyc(1);
    s_idle;
    s_timer;
    s_pause;
    s_therm;
    s_fault;
    s_volt;
    s_module;
    give_verdict(0);
  end
endmodule // cell_balance_stop_pause_ctrl_tb_top
`default_nettype wire
